// [abps_pkg.sv]
// Purpose: Shared constants and types for the adapter/battery power selector
// Assumes: 50 MHz system clock, comparator inputs already synchronous
// Notes:   All delays are counted in 1 ms ticks of the system clock

package abps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TICK_MS        = 1;
    localparam int MS_CYC         = CLK_HZ / 1000 * TICK_MS;
    localparam int T_GATE_MS      = 20;
    localparam int T_SHORT_MS     = 150;
    localparam int T_LONG_MS      = 1300;
    localparam int T_WIN_S        = 90;
    localparam int T_WIN_MS       = T_WIN_S * 1000;
    localparam int FAIL_LIMIT     = 7;
    localparam int TW             = 17;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_OPTION   = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
    localparam logic [11:0] ADDR_VREG     = 12'h010;

    localparam int          OPT_DEGLITCH_BIT = 15;
    localparam int          OPT_DEPL_LSB     = 11;
    localparam int          OPT_BATTERY_CYCLE_A_BIT    = 6;
    localparam logic [15:0] OPT_RESET        = 16'h8000;
    localparam logic [15:0] OPT_WMASK        = 16'h9840;
    localparam logic [15:0] VREG_RESET       = 16'h0000;

    // Depletion fractions of regulation level, scaled by 4096
    localparam logic [11:0] DEPL_K0 = 12'h978;
    localparam logic [11:0] DEPL_K1 = 12'ha06;
    localparam logic [11:0] DEPL_K2 = 12'haa6;
    localparam logic [11:0] DEPL_K3 = 12'hb5b;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_OVP        = 0;
    localparam int IRQ_GATE_FAIL  = 1;
    localparam int IRQ_LATCH      = 2;
    localparam int IRQ_BATTERY_CYCLE_A_DONE = 3;
    localparam int IRQ_TO_ADAPTER = 4;
    localparam int IRQ_W          = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BAT     = 3'h0,
        ST_BRK_AC  = 3'h1,
        ST_AC_CHK  = 3'h3,
        ST_AC_RUN  = 3'h2,
        ST_BRK_BAT = 3'h6,
        ST_RETRY   = 3'h7,
        ST_LATCH   = 3'h5
    } abps_state_e;

    typedef struct packed {
        logic supply_undervoltage_lockout_ok;
        logic batt_undervoltage_lockout_ok;
        logic det_above_0v6;
        logic det_above_2v4;
        logic det_above_3v15;
        logic supply_over_batt;
        logic acn_near_batt;
        logic gate_vgs_ok;
    } abps_cmp_s;

    typedef struct packed {
        abps_state_e       state;
        logic [15:0]       opt;
        logic [15:0]       vreg;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic [31:0]       prdata;
        logic [15:0]       ms_cnt;
        logic [TW-1:0]     dg_cnt;
        logic [TW-1:0]     tmr;
        logic [TW-1:0]     win_cnt;
        logic [2:0]        fail_cnt;
        logic              ok;
        logic              ovp;
        logic              first;
        logic              long_eff;
        logic              dropped;
        logic              ac_drv;
        logic              bat_drv;
        logic              chg;
    } abps_st_s;

    localparam abps_st_s ST_RESET_VAL = '{
        state: ST_BAT, opt: OPT_RESET, vreg: VREG_RESET, first: 1'b1, default: '0
    };

endpackage

// [abps_power_select.sv]
// Purpose: Adapter qualification and adapter/battery switch sequencing
// Assumes: Comparator inputs synchronous to clk; APB slave, always ready
// Notes:   All state in one struct; adapter detect below 0.6V is a soft reset
//
// Functional notes
// - Adapter ok only with supply good, detect in window, supply above battery.
// - First qualification after power-on uses the 150 ms deglitch.
// - Detect below 0.6V resets logic and selects 1.3 s deglitch next.
// - Deglitch choice applies after detect dropped and adapter switch turned off.
// - Option bit 15 clear picks 150 ms; bus usable only when powered.
// - Detect overvoltage: flag it, drop ok, stop charge, adapter off.
// - Detect back in window: ok again, battery off, adapter switches on.
// - After power-on the battery is connected if present. The code keeps it off while detect is below 0.6V.
// - Outgoing switch off before incoming switch on.
// - Without adapter hold its gate low; battery gate on if conditions hold. The code holds the battery gate off while detect is below 0.6V.
// - After deglitch switch to adapter unless battery_cycle_a and battery above threshold.
// - Gate not good 20 ms after turn-on: switch off, retry after 1.3 s.
// - Seven failures in 90 s latch off; count clears after 90 s.
// - No charging while the adapter switches are off.
// - Adapter switches off when ok low or learning above threshold.
// - Option bit 6 enables battery_cycle_a cycle, forcing the system onto battery.
// - Battery below threshold during battery_cycle_a: exit, back to adapter, clear bit.
// - Option bits 12:11 select the depletion fraction of regulation level.
//
// Implementation choices: the APB slave port and the address map.

module abps_power_select
    import abps_pkg::*;
#(
    parameter int P_MS_CYC   = MS_CYC,
    parameter int P_T_GATE   = T_GATE_MS,
    parameter int P_T_SHORT  = T_SHORT_MS,
    parameter int P_T_LONG   = T_LONG_MS,
    parameter int P_T_WIN    = T_WIN_MS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog comparators and battery level
    input  wire abps_cmp_s   cmp,
    input  wire logic [15:0] batt_level,
    // Adapter ok open-drain pin
    output logic             adapter_ok_out_o,
    output logic             adapter_ok_out_oe,
    // Switch gate drives and status
    output logic             adapter_gate_drive,
    output logic             battery_gate_drive,
    output logic             charge_enable,
    output logic             adapter_overvoltage,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    abps_st_s r_reg;
    abps_st_s r_next;

    localparam logic [15:0]   MS_LAST    = 16'(P_MS_CYC - 1);
    localparam logic [TW-1:0] GATE_LAST  = TW'(P_T_GATE - 1);
    localparam logic [TW-1:0] SHORT_LAST = TW'(P_T_SHORT - 1);
    localparam logic [TW-1:0] LONG_LAST  = TW'(P_T_LONG - 1);
    localparam logic [TW-1:0] WIN_LAST   = TW'(P_T_WIN - 1);
    localparam logic [2:0]    FAIL_LAST  = 3'(FAIL_LIMIT - 1);

    logic             tick;
    logic             raw_ok;
    logic             bat_allow;
    logic             below;
    logic             battery_cycle_a;
    logic             leave_ac;
    logic             bus_en;
    logic             mapped;
    logic [11:0]      depl_k;
    logic [27:0]      lhs;
    logic [27:0]      rhs;
    logic [TW-1:0]    dg_last;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic [31:0]      status;
    logic [31:0]      rd_val;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        ev     = '0;
        w1c    = '0;

        // Millisecond tick
        tick = (r_reg.ms_cnt == MS_LAST);
        r_next.ms_cnt = tick ? 16'h0000 : 16'(r_reg.ms_cnt + 16'h0001);

        // Adapter qualification
        raw_ok = cmp.supply_undervoltage_lockout_ok & cmp.det_above_2v4 &
                 ~cmp.det_above_3v15 & cmp.supply_over_batt;
        r_next.ovp = cmp.det_above_3v15;
        if (cmp.det_above_3v15 && !r_reg.ovp) begin
            ev[IRQ_OVP] = 1'b1;
        end

        if (r_reg.first || !r_reg.long_eff) begin
            dg_last = SHORT_LAST;
        end else begin
            dg_last = LONG_LAST;
        end

        if (!raw_ok) begin
            r_next.ok     = 1'b0;
            r_next.dg_cnt = '0;
        end else if (!r_reg.ok && tick) begin
            if (r_reg.dg_cnt >= dg_last) begin
                r_next.ok    = 1'b1;
                r_next.first = 1'b0;
            end else begin
                r_next.dg_cnt = TW'(r_reg.dg_cnt + 1'b1);
            end
        end

        // Deglitch option takes effect after a drop and an adapter turn-off
        if (!cmp.det_above_2v4) begin
            r_next.dropped = 1'b1;
        end
        if (r_reg.dropped && !r_reg.ac_drv) begin
            r_next.long_eff = r_reg.opt[OPT_DEGLITCH_BIT];
            r_next.dropped  = !cmp.det_above_2v4;
        end

        // Depletion threshold
        case (r_reg.opt[OPT_DEPL_LSB +: 2])
            2'h0:    depl_k = DEPL_K0;
            2'h1:    depl_k = DEPL_K1;
            2'h2:    depl_k = DEPL_K2;
            default: depl_k = DEPL_K3;
        endcase
        lhs   = {batt_level, 12'h000};
        rhs   = 28'(r_reg.vreg) * 28'(depl_k);
        below = (lhs < rhs);
        battery_cycle_a = r_reg.opt[OPT_BATTERY_CYCLE_A_BIT];
        leave_ac  = !r_reg.ok || (battery_cycle_a && !below);
        bat_allow = cmp.supply_undervoltage_lockout_ok & cmp.batt_undervoltage_lockout_ok & cmp.acn_near_batt;

        // Failure window
        if (r_reg.fail_cnt == 3'h0) begin
            r_next.win_cnt = '0;
        end else if (tick) begin
            if (r_reg.win_cnt >= WIN_LAST) begin
                r_next.win_cnt  = '0;
                r_next.fail_cnt = 3'h0;
            end else begin
                r_next.win_cnt = TW'(r_reg.win_cnt + 1'b1);
            end
        end

        // Selector sequencing
        case (r_reg.state)
            ST_BAT: begin
                if (r_reg.ok && (!battery_cycle_a || below)) begin
                    r_next.state = ST_BRK_AC;
                    if (battery_cycle_a) begin
                        r_next.opt[OPT_BATTERY_CYCLE_A_BIT] = 1'b0;
                        ev[IRQ_BATTERY_CYCLE_A_DONE]        = 1'b1;
                    end
                end
            end
            ST_BRK_AC: begin
                r_next.state = ST_AC_CHK;
                r_next.tmr   = '0;
            end
            ST_AC_CHK: begin
                if (leave_ac) begin
                    r_next.state = ST_BRK_BAT;
                end else if (cmp.gate_vgs_ok) begin
                    r_next.state = ST_AC_RUN;
                    ev[IRQ_TO_ADAPTER] = 1'b1;
                end else if (tick) begin
                    if (r_reg.tmr >= GATE_LAST) begin
                        ev[IRQ_GATE_FAIL] = 1'b1;
                        r_next.tmr        = '0;
                        if (r_reg.fail_cnt == FAIL_LAST) begin
                            r_next.state   = ST_LATCH;
                            ev[IRQ_LATCH]  = 1'b1;
                        end else begin
                            r_next.state    = ST_RETRY;
                            r_next.fail_cnt = 3'(r_reg.fail_cnt + 3'h1);
                        end
                    end else begin
                        r_next.tmr = TW'(r_reg.tmr + 1'b1);
                    end
                end
            end
            ST_AC_RUN: begin
                if (leave_ac) begin
                    r_next.state = ST_BRK_BAT;
                end
            end
            ST_BRK_BAT: begin
                r_next.state = ST_BAT;
            end
            ST_RETRY: begin
                if (!r_reg.ok) begin
                    r_next.state = ST_BAT;
                end else if (tick) begin
                    if (r_reg.tmr >= LONG_LAST) begin
                        r_next.state = ST_BRK_AC;
                    end else begin
                        r_next.tmr = TW'(r_reg.tmr + 1'b1);
                    end
                end
            end
            ST_LATCH: begin
                r_next.state = ST_LATCH;
            end
            default: begin
                r_next.state = ST_BAT;
            end
        endcase

        // Registered drives; break states keep both gates off
        r_next.ac_drv  = (r_next.state == ST_AC_CHK) ||
                         (r_next.state == ST_AC_RUN);
        r_next.bat_drv = bat_allow && !r_reg.ac_drv && ((r_next.state == ST_BAT) ||
                         (r_next.state == ST_RETRY) ||
                         (r_next.state == ST_LATCH));
        r_next.chg     = (r_next.state == ST_AC_RUN) && r_next.ok &&
                         !r_next.ovp;

        // APB slave
        bus_en = cmp.supply_undervoltage_lockout_ok & cmp.det_above_0v6;
        mapped = (paddr == ADDR_OPTION) || (paddr == ADDR_STATUS) ||
                 (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK) ||
                 (paddr == ADDR_VREG);
        status = {16'h0000, 2'h0, r_reg.fail_cnt, r_reg.state, r_reg.long_eff,
                  r_reg.first, r_reg.chg, r_reg.bat_drv, r_reg.ac_drv,
                  r_reg.ovp, r_reg.ok, 1'b0};
        case (paddr)
            ADDR_OPTION:   rd_val = {16'h0000, r_reg.opt};
            ADDR_STATUS:   rd_val = status;
            ADDR_IRQ_STAT: rd_val = {27'h0, r_reg.irq_stat};
            ADDR_IRQ_MASK: rd_val = {27'h0, r_reg.irq_mask};
            ADDR_VREG:     rd_val = {16'h0000, r_reg.vreg};
            default:       rd_val = 32'h0000_0000;
        endcase
        if (psel && !penable) begin
            r_next.prdata = (bus_en && !pwrite) ? rd_val : 32'h0000_0000;
        end
        if (psel && penable && pwrite && bus_en) begin
            case (paddr)
                ADDR_OPTION:   r_next.opt      = pwdata[15:0] & OPT_WMASK;
                ADDR_IRQ_STAT: w1c             = pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: r_next.irq_mask = pwdata[IRQ_W-1:0];
                ADDR_VREG:     r_next.vreg     = pwdata[15:0];
                default:       w1c             = '0;
            endcase
        end
        // New events win over a clear in the same cycle
        r_next.irq_stat = (r_reg.irq_stat & ~w1c) | ev;

        // Detect below 0.6V resets all, next deglitch long
        if (!cmp.det_above_0v6) begin
            r_next          = ST_RESET_VAL;
            r_next.first    = 1'b0;
            r_next.long_eff = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= ST_RESET_VAL;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata              = r_reg.prdata;
    assign pready              = 1'b1;
    assign pslverr             = psel & penable &
                                 ~(cmp.supply_undervoltage_lockout_ok & cmp.det_above_0v6 & mapped);
    assign adapter_ok_out_o    = 1'b0;
    assign adapter_ok_out_oe   = ~r_reg.ok;
    assign adapter_gate_drive  = r_reg.ac_drv;
    assign battery_gate_drive  = r_reg.bat_drv;
    assign charge_enable       = r_reg.chg;
    assign adapter_overvoltage = r_reg.ovp;
    assign irq                 = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule

// [abps_asserts.sv]
// Purpose: Port-level checks of the power selector
// Assumes: One clock domain, synchronous active-high rst
// Notes:   Delay bounds scale with the bound parameters
module abps_asserts
    import abps_pkg::*;
#(
    parameter int P_MS_CYC  = MS_CYC,
    parameter int P_T_GATE  = T_GATE_MS,
    parameter int P_T_SHORT = T_SHORT_MS
) (
    // Clock, reset, bus
    input wire logic      clk,
    input wire logic      rst,
    input wire logic      psel,
    input wire logic      penable,
    input wire logic      pslverr,
    // Sensing and drives
    input wire abps_cmp_s cmp,
    input wire logic      adapter_ok_out_oe,
    input wire logic      adapter_gate_drive,
    input wire logic      battery_gate_drive,
    input wire logic      charge_enable,
    input wire logic      adapter_overvoltage
);
    localparam int CHK_MAX = (P_T_GATE + 1) * P_MS_CYC + 2;
    localparam int DG_MIN  = (P_T_SHORT - 1) * P_MS_CYC;
    logic        raw;
    logic        vgs_seen;
    logic [31:0] raw_cnt;
    logic [31:0] chk_cnt;
    assign raw = cmp.supply_undervoltage_lockout_ok && cmp.det_above_2v4 && !cmp.det_above_3v15
                 && cmp.supply_over_batt;
    // Run lengths of raw ok and of an unconfirmed gate turn-on
    always_ff @(posedge clk) begin
        raw_cnt <= (rst || !raw) ? '0 : raw_cnt + 32'h1;
        vgs_seen <= adapter_gate_drive && (vgs_seen || cmp.gate_vgs_ok);
        chk_cnt <= (!adapter_gate_drive || vgs_seen || cmp.gate_vgs_ok) ? '0 : chk_cnt + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    bbm_excl_a: assert property (!(adapter_gate_drive && battery_gate_drive))
        else $error("both gate drives high");
    ac_gap_a: assert property ($rose(adapter_gate_drive) |-> !$past(battery_gate_drive))
        else $error("adapter gate on without gap");
    bat_gap_a: assert property ($rose(battery_gate_drive) |-> !$past(adapter_gate_drive))
        else $error("battery gate on without gap");
    chg_gate_a: assert property (charge_enable |-> adapter_gate_drive)
        else $error("charging with adapter switch off");
    ovp_flag_a: assert property (cmp.det_above_3v15 |=> adapter_overvoltage)
        else $error("overvoltage not flagged");
    ovp_off_a: assert property (
        cmp.det_above_3v15 |-> ##[1:3] !(adapter_gate_drive || charge_enable))
        else $error("adapter path kept on in overvoltage");
    ok_drop_a: assert property (!raw |=> adapter_ok_out_oe)
        else $error("adapter ok released without conditions");
    no_adp_a: assert property (!cmp.det_above_2v4 |-> ##[1:3] !adapter_gate_drive)
        else $error("adapter gate on without adapter");
    gate_chk_a: assert property (chk_cnt <= CHK_MAX)
        else $error("gate check timeout missed");
    dglt_min_a: assert property ($fell(adapter_ok_out_oe) |-> raw_cnt >= DG_MIN)
        else $error("adapter ok rose before deglitch");
    bus_off_a: assert property (
        psel && penable && !(cmp.supply_undervoltage_lockout_ok && cmp.det_above_0v6) |-> pslverr)
        else $error("bus access accepted while unpowered");
endmodule

bind abps_power_select abps_asserts #(
    .P_MS_CYC (P_MS_CYC),
    .P_T_GATE (P_T_GATE),
    .P_T_SHORT(P_T_SHORT)
) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pslverr(pslverr), .cmp(cmp),
    .adapter_ok_out_oe(adapter_ok_out_oe), .adapter_gate_drive(adapter_gate_drive),
    .battery_gate_drive(battery_gate_drive), .charge_enable(charge_enable),
    .adapter_overvoltage(adapter_overvoltage)
);

// [abps_far_model.sv]
// Purpose: Adapter and battery seen through the comparators
// Assumes: ac_mode 0 below 0.6V, 1 below 2.4V, 2 in window, 3 overvoltage
// Notes:   Gate voltage good two cycles after drive unless gate_bad
module abps_far_model
    import abps_pkg::*;
(
    // Clock and controls
    input wire logic        clk,
    input wire logic [1:0]  ac_mode,
    input wire logic        gate_bad,
    input wire logic [15:0] batt_mv,
    input wire logic        adapter_gate_drive,
    // Comparator outputs
    output abps_cmp_s       cmp,
    output logic     [15:0] batt_level
);
    logic [1:0] vgs_sr = 2'h0;
    always_ff @(posedge clk) begin
        vgs_sr <= (adapter_gate_drive && !gate_bad) ? {vgs_sr[0], 1'b1} : 2'h0;
    end
    always_comb begin
        cmp.supply_undervoltage_lockout_ok   = 1'b1;
        cmp.batt_undervoltage_lockout_ok     = 1'b1;
        cmp.det_above_0v6    = ac_mode != 2'd0;
        cmp.det_above_2v4    = ac_mode[1];
        cmp.det_above_3v15   = ac_mode == 2'd3;
        cmp.supply_over_batt = 1'b1;
        cmp.acn_near_batt    = !adapter_gate_drive;
        cmp.gate_vgs_ok      = vgs_sr[1];
        batt_level           = batt_mv;
    end
endmodule

// [abps_tb.sv]
// Purpose: Self-checking bench for the power selector
// Assumes: Scaled timing parameters, tick every 4 cycles
// Notes:   Reads compared by a monitor against queued notes
module testbench
    import abps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 4, TG = 3, TS = 5, TL = 8;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, gate_bad = 0, last_err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [1:0]  ac_mode = 2'd1;
    logic [15:0] batt_mv = 16'h0384, batt_level;
    logic pready, pslverr, ok_o, ok_oe, ac_drv, bat_drv, chg, ovp, irq;
    abps_cmp_s   cmp;
    logic [11:0] kt[4] = '{DEPL_K0, DEPL_K1, DEPL_K2, DEPL_K3};
    logic [31:0] exp_q[$], msk_q[$];
    int err_total = 0, total_checks = 0, n, vreg, thr;

    always #10 clk = ~clk;

    abps_power_select #(.P_MS_CYC(MS), .P_T_GATE(TG), .P_T_SHORT(TS), .P_T_LONG(TL),
        .P_T_WIN(100)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp(cmp), .batt_level(batt_level), .adapter_ok_out_o(ok_o),
        .adapter_ok_out_oe(ok_oe), .adapter_gate_drive(ac_drv), .battery_gate_drive(bat_drv),
        .charge_enable(chg), .adapter_overvoltage(ovp), .irq(irq));
    abps_far_model far (.clk(clk), .ac_mode(ac_mode), .gate_bad(gate_bad), .batt_mv(batt_mv),
        .adapter_gate_drive(ac_drv), .cmp(cmp), .batt_level(batt_level));

    task finish_test;
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task check_pin(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        last_err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_run;
        n = 0;
        do begin @(posedge clk); n++; end while (chg !== 1'b1 && n < 300);
        check_pin("charge", 1, {31'h0, chg});
        check_pin("drives", 2, {30'h0, ac_drv, bat_drv});
    endtask
    task qualify(input int lo, input int hi);
        n = 0;
        ac_mode <= 2'd2;
        do begin @(posedge clk); n++; end while (ok_oe !== 1'b0 && n < 400);
        check_pin("ok delay", 1, 32'(n >= lo && n <= hi));
        wait_run;
    endtask

    always @(posedge clk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check_pin("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test;
    end

    initial begin
        void'($urandom(5909));
        cyc(4);
        rst <= 0;
        rd(ADDR_OPTION, 32'h8000, 32'hffff);
        rd(12'h014, 0, 32'hffffffff);
        check_pin("slverr", 1, {31'h0, last_err});
        check_pin("reset drives", 32'h5, {28'h0, ok_o, ok_oe, ac_drv, bat_drv});
        wr_mask: apb(1'b1, ADDR_IRQ_MASK, 32'h1f);
        qualify(16, 28);
        check_pin("irq", 1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
        check_pin("irq", 0, {31'h0, irq});
        ac_mode <= 2'd3;
        cyc(6);
        check_pin("ovp", 32'h19, {27'h0, ovp, ok_oe, ac_drv, chg, bat_drv});
        ac_mode <= 2'd2;
        wait_run;
        ac_mode <= 2'd1;
        cyc(6);
        check_pin("drop", 1, {30'h0, ac_drv, bat_drv});
        qualify(29, 44);
        apb(1'b1, ADDR_OPTION, 32'h0);
        ac_mode <= 2'd1;
        cyc(6);
        qualify(16, 28);
        vreg = 400 + $urandom % 3000;
        apb(1'b1, ADDR_VREG, 32'(vreg));
        for (int s = 0; s < 4; s++) begin
            thr = vreg * int'(kt[s]) / 4096;
            batt_mv <= 16'(thr + 1);
            apb(1'b1, ADDR_OPTION, 32'(s << 11) | 32'h40);
            cyc(6);
            check_pin("battery_cycle_a", 1, {30'h0, ac_drv, bat_drv});
            rd(ADDR_OPTION, 32'(s << 11) | 32'h40, 32'hffff);
            batt_mv <= 16'(thr - 1);
            wait_run;
            rd(ADDR_OPTION, 32'(s << 11), 32'hffff);
        end
        ac_mode <= 2'd1;
        cyc(6);
        gate_bad <= 1;
        ac_mode <= 2'd2;
        for (int i = 0; i < 7; i++) begin
            n = 0;
            do begin @(posedge clk); n++; end while (ac_drv !== 1'b1 && n < 200);
            n = 0;
            do begin @(posedge clk); n++; end while (ac_drv !== 1'b0 && n < 40);
            check_pin("gate fail", 1, 32'(n <= (TG + 1) * MS + 4));
        end
        cyc(100);
        check_pin("latched", 0, {31'h0, ac_drv});
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        check_pin("masked irq", 0, {31'h0, irq});
        rd(ADDR_IRQ_STAT, 32'h06, 32'h06);
        apb(1'b1, ADDR_IRQ_MASK, 32'h4);
        check_pin("irq", 1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_STAT, 32'h4);
        check_pin("irq", 0, {31'h0, irq});
        ac_mode <= 2'd0;
        gate_bad <= 0;
        cyc(4);
        rd(ADDR_OPTION, 0, 32'hffff);
        check_pin("slverr", 1, {31'h0, last_err});
        qualify(29, 44);
        rd(ADDR_OPTION, 32'h8000, 32'hffff);
        finish_test;
    end
endmodule
